// File: stk_pkg.sv
// Shared constants and types of the numeric stripe track decoder
package stk_pkg;

  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int SYS_PERIOD_NS = 4;
  localparam int DATA_SETUP_NS = 1000;
  localparam int STROBE_LOW_NS = 2000;
  localparam int CARD_TIMEOUT_MS = 150;
  localparam int SETUP_CYC = (DATA_SETUP_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int LOW_CYC = (STROBE_LOW_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int TIMEOUT_CYC = (CARD_TIMEOUT_MS * 1000000) / SYS_PERIOD_NS;

  // ----------------------------------------
  // Track format
  // ----------------------------------------
  localparam int PRESENT_REV = 14;
  localparam int LEAD_ZEROS_LO = 22;
  localparam int LEAD_ZEROS_HI = 62;
  localparam logic [6:0] MAX_CHARS_LO = 7'h25;
  localparam logic [6:0] MAX_CHARS_HI = 7'h68;
  localparam int CHAR_BITS = 5;
  localparam logic [2:0] LAST_BIT = 3'h4;
  localparam logic [4:0] START_CHAR = 5'h0b;
  localparam logic [4:0] END_CHAR = 5'h1f;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic parity;
    logic [3:0] data;
  } stk_char_t;

  typedef struct packed {
    logic ss_seen;
    logic es_seen;
    logic parity_err;
    logic check_err;
    logic overflow;
    logic done;
  } stk_status_t;

  typedef enum logic [1:0] {FR_HUNT, FR_CHARS, FR_CHECK, FR_DONE} stk_frame_t;
  typedef enum logic [1:0] {SB_IDLE, SB_SETUP, SB_LOW} stk_strobe_t;

endpackage

// File: stk_decoder.sv
// Numeric stripe track reader: F2F recovery, strobe output, framing check
// Contract
// - Leading clocking zeros precede start sentinel, 22 or 62 per track.
// - First character is start sentinel hex B, read as 11010.
// - At most 37 or 104 data characters between sentinels.
// - Data ends with end sentinel hex F, all five bits ones.
// - Check character follows end sentinel with no bits between.
// - At least 22 or 62 trailing clocking zeros follow check character.
// - Characters are four weighted data bits plus one parity bit.
// - Bits arrive weight 1,2,4,8 then parity; reassemble that way.
// - Every character has odd parity; even parity flagged as error.
// - Check character data is XOR of all data from start to end.
// - Check character has its own odd parity over its data.
// - F2F: transition each cell boundary, extra mid-cell one for ones.
// - Densities 75 or 210 bpi; timing recovered from transitions.
// - Card present times out about 150 ms after last transition.
// - Data holds a valid bit the whole time strobe is low.
// - Data is active low: high is zero, low is one.
// - Card present goes low after 14 to 15 reversals; strobes after.
// - With no card, data, strobe and card present rest high.
module stk_decoder #(
  parameter int TIMEOUT = stk_pkg::TIMEOUT_CYC,
  parameter int CELL_W = 20,
  parameter logic [6:0] MAX_LO = stk_pkg::MAX_CHARS_LO,
  parameter logic [6:0] MAX_HI = stk_pkg::MAX_CHARS_HI
) (
  // System clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Head clock domain
  input wire logic clk_head,
  input wire logic head_rst,
  input wire logic flux_in,
  // Track select, high for the dense track
  input wire logic track_hi,
  // Reader pins
  output logic card_present_n,
  output logic strobe_n,
  output logic data_n,
  // Character report
  output stk_pkg::stk_char_t char_out,
  output logic char_valid,
  output stk_pkg::stk_status_t status
);

  // ----------------------------------------
  // Head domain: flux edge to toggle
  // ----------------------------------------
  logic head_s1_reg, head_s2_reg, head_s3_reg, head_tgl_reg;
  wire head_edge = head_s2_reg ^ head_s3_reg;

  always_ff @(posedge clk_head) begin
    if (head_rst) begin
      head_s1_reg <= 1'b0;
      head_s2_reg <= 1'b0;
      head_s3_reg <= 1'b0;
      head_tgl_reg <= 1'b0;
    end else begin
      head_s1_reg <= flux_in;
      head_s2_reg <= head_s1_reg;
      head_s3_reg <= head_s2_reg;
      head_tgl_reg <= head_tgl_reg ^ head_edge;
    end
  end

  // ----------------------------------------
  // Toggle crossing into system domain
  // ----------------------------------------
  logic tgl_s1_reg, tgl_s2_reg, tgl_s3_reg;
  wire flux_evt = tgl_s2_reg ^ tgl_s3_reg;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      tgl_s1_reg <= 1'b0;
      tgl_s2_reg <= 1'b0;
      tgl_s3_reg <= 1'b0;
    end else begin
      tgl_s1_reg <= head_tgl_reg;
      tgl_s2_reg <= tgl_s1_reg;
      tgl_s3_reg <= tgl_s2_reg;
    end
  end

  // ----------------------------------------
  // F2F bit recovery and card presence
  // ----------------------------------------
  logic [CELL_W-1:0] since_reg, ref_reg, since_next, ref_next;
  logic [3:0] rev_reg, rev_next;
  logic [25:0] idle_reg, idle_next;
  logic half_reg, half_next, present_reg, present_next;

  wire [CELL_W-1:0] thr = ref_reg - (ref_reg >> 2);
  wire since_max = &since_reg;
  wire timed_out = (idle_reg == 26'(TIMEOUT - 1)) && !flux_evt;
  wire rev_full = (rev_reg == 4'(stk_pkg::PRESENT_REV - 1));
  // short interval is a mid-cell reversal
  wire is_mid = flux_evt && !half_reg && (ref_reg != '0) && (since_reg < thr);
  wire is_bnd = flux_evt && !is_mid;
  // bit timing follows the last measured cell
  wire bit_go = is_bnd && present_reg && (ref_reg != '0);
  wire bit_val = half_reg;

  assign since_next = is_bnd ? '0 : (since_max ? since_reg : since_reg + 1'b1);
  assign ref_next = timed_out ? '0 : ((is_bnd && rev_reg != '0) ? since_reg : ref_reg);
  assign half_next = timed_out ? 1'b0 : (is_mid ? 1'b1 : (is_bnd ? 1'b0 : half_reg));
  assign rev_next = timed_out ? '0 : ((flux_evt && !rev_full) ? rev_reg + 1'b1 : rev_reg);
  assign present_next = timed_out ? 1'b0 : ((flux_evt && rev_full) ? 1'b1 : present_reg);
  assign idle_next = flux_evt ? '0 : (timed_out ? idle_reg : idle_reg + 1'b1);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      since_reg <= '0;
      ref_reg <= '0;
      half_reg <= 1'b0;
      rev_reg <= '0;
      present_reg <= 1'b0;
      idle_reg <= '0;
    end else begin
      since_reg <= since_next;
      ref_reg <= ref_next;
      half_reg <= half_next;
      rev_reg <= rev_next;
      present_reg <= present_next;
      idle_reg <= idle_next;
    end
  end

  // ----------------------------------------
  // Strobe and data pins
  // ----------------------------------------
  stk_pkg::stk_strobe_t sb_reg, sb_next;
  logic [9:0] sb_cnt_reg, sb_cnt_next;
  logic strobe_n_reg, data_n_reg, cp_n_reg;
  wire sb_zero = (sb_cnt_reg == '0);

  always_comb begin
    sb_next = sb_reg;
    sb_cnt_next = sb_zero ? sb_cnt_reg : sb_cnt_reg - 1'b1;
    case (sb_reg)
      stk_pkg::SB_IDLE: begin
        if (bit_go) begin
          sb_next = stk_pkg::SB_SETUP;
          sb_cnt_next = 10'(stk_pkg::SETUP_CYC - 1);
        end
      end
      stk_pkg::SB_SETUP: begin
        if (sb_zero) begin
          sb_next = stk_pkg::SB_LOW;
          sb_cnt_next = 10'(stk_pkg::LOW_CYC - 1);
        end
      end
      default: begin
        if (sb_zero) begin
          sb_next = stk_pkg::SB_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sb_reg <= stk_pkg::SB_IDLE;
      sb_cnt_reg <= '0;
    end else begin
      sb_reg <= sb_next;
      sb_cnt_reg <= sb_cnt_next;
    end
  end

  // held while busy, one drives low
  wire data_n_next = (sb_reg == stk_pkg::SB_IDLE) ? (bit_go ? ~bit_val : 1'b1) : data_n_reg;
  // pins rest high without a card
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      strobe_n_reg <= 1'b1;
      data_n_reg <= 1'b1;
      cp_n_reg <= 1'b1;
    end else begin
      strobe_n_reg <= (sb_next != stk_pkg::SB_LOW);
      data_n_reg <= data_n_next;
      cp_n_reg <= ~present_next;
    end
  end

  assign strobe_n = strobe_n_reg;
  assign data_n = data_n_reg;
  assign card_present_n = cp_n_reg;

  // ----------------------------------------
  // Character framing and checking
  // ----------------------------------------
  stk_pkg::stk_frame_t fr_reg, fr_next;
  stk_pkg::stk_status_t st_reg, st_next;
  stk_pkg::stk_char_t ch_reg, ch_next;
  logic [4:0] sh_reg;
  logic [3:0] lrc_reg, lrc_next;
  logic [2:0] bc_reg;
  logic [6:0] cnt_reg, cnt_next;
  logic valid_reg, valid_next;

  // least significant bit first, parity last
  wire [4:0] sh_next = {bit_val, sh_reg[4:1]};
  wire new_card = present_next && !present_reg;
  wire in_char = (fr_reg == stk_pkg::FR_CHARS) || (fr_reg == stk_pkg::FR_CHECK);
  wire char_done = bit_go && in_char && (bc_reg == stk_pkg::LAST_BIT);
  wire par_ok = ^sh_next;
  wire [6:0] max_chars = track_hi ? MAX_HI : MAX_LO;

  always_comb begin
    fr_next = fr_reg;
    st_next = st_reg;
    ch_next = ch_reg;
    lrc_next = lrc_reg;
    cnt_next = cnt_reg;
    valid_next = 1'b0;
    case (fr_reg)
      stk_pkg::FR_HUNT: begin
        if (bit_go && sh_next == stk_pkg::START_CHAR) begin
          fr_next = stk_pkg::FR_CHARS;
          st_next.ss_seen = 1'b1;
          ch_next = sh_next;
          lrc_next = sh_next[3:0];
          valid_next = 1'b1;
        end
      end
      stk_pkg::FR_CHARS: begin
        if (char_done) begin
          ch_next = sh_next;
          valid_next = 1'b1;
          lrc_next = lrc_reg ^ sh_next[3:0];
          st_next.parity_err = st_reg.parity_err | ~par_ok;
          if (sh_next == stk_pkg::END_CHAR) begin
            fr_next = stk_pkg::FR_CHECK;
            st_next.es_seen = 1'b1;
          end else begin
            cnt_next = cnt_reg + 1'b1;
            st_next.overflow = st_reg.overflow | (cnt_reg == max_chars);
          end
        end
      end
      stk_pkg::FR_CHECK: begin
        // very next character is the check
        if (char_done) begin
          ch_next = sh_next;
          valid_next = 1'b1;
          fr_next = stk_pkg::FR_DONE;
          st_next.done = 1'b1;
          st_next.parity_err = st_reg.parity_err | ~par_ok;
          st_next.check_err = |(lrc_reg ^ sh_next[3:0]);
        end
      end
      default: begin
        fr_next = stk_pkg::FR_DONE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst || new_card) begin
      fr_reg <= stk_pkg::FR_HUNT;
      st_reg <= '0;
      ch_reg <= '0;
      sh_reg <= '0;
      lrc_reg <= '0;
      bc_reg <= '0;
      cnt_reg <= '0;
      valid_reg <= 1'b0;
    end else begin
      fr_reg <= fr_next;
      st_reg <= st_next;
      ch_reg <= ch_next;
      sh_reg <= bit_go ? sh_next : sh_reg;
      lrc_reg <= lrc_next;
      bc_reg <= !in_char ? '0 : (!bit_go ? bc_reg : (char_done ? '0 : bc_reg + 1'b1));
      cnt_reg <= cnt_next;
      valid_reg <= valid_next;
    end
  end

  assign char_out = ch_reg;
  assign char_valid = valid_reg;
  assign status = st_reg;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence s_mid;
    is_mid;
  endsequence

  AST_STROBE_NEEDS_CARD: assert property ($fell(strobe_n) |-> !card_present_n)
    else $error("strobe fell without card present");
  AST_IDLE_HIGH: assert property (
    card_present_n && sb_reg == stk_pkg::SB_IDLE |-> strobe_n && data_n)
    else $error("pins not high while idle");
  AST_DATA_HOLD: assert property (!strobe_n && $past(!strobe_n) |-> $stable(data_n))
    else $error("data moved while strobe low");
  AST_ONE_BIT_LOW: assert property (
    bit_go && bit_val && sb_reg == stk_pkg::SB_IDLE |=> !data_n)
    else $error("one bit not driven low");
  AST_MID_SETS_HALF: assert property (s_mid |=> half_reg)
    else $error("mid-cell reversal not held");
  AST_TIMEOUT: assert property (timed_out && present_reg |=> card_present_n)
    else $error("card present did not time out");
  AST_START_ALIGN: assert property (
    fr_reg == stk_pkg::FR_HUNT && bit_go && sh_next == stk_pkg::START_CHAR
    |=> fr_reg == stk_pkg::FR_CHARS && char_valid && char_out == stk_pkg::START_CHAR)
    else $error("start sentinel missed");
  AST_PARITY: assert property (char_done && !par_ok |=> status.parity_err)
    else $error("even parity not flagged");
  AST_END_TO_CHECK: assert property (
    char_done && fr_reg == stk_pkg::FR_CHARS && sh_next == stk_pkg::END_CHAR
    |=> fr_reg == stk_pkg::FR_CHECK && status.es_seen && char_out == stk_pkg::END_CHAR)
    else $error("end sentinel not taken");
  AST_CHECK_SUM: assert property (char_done && fr_reg == stk_pkg::FR_CHECK
    |=> status.done && (status.check_err == |(lrc_reg ^ char_out.data)))
    else $error("check character result wrong");
  AST_OVERFLOW: assert property (
    char_done && fr_reg == stk_pkg::FR_CHARS && sh_next != stk_pkg::END_CHAR
    && cnt_reg == max_chars |=> status.overflow)
    else $error("character limit not flagged");

endmodule

// File: stk_decoder_unused_guard.sv
// Spare file of the stripe track decoder, holds no logic

// File: stk_host_model.sv
// Host controller model sampling the reader pins
module stk_host_model (
  // Reader pins
  input wire logic card_present_n,
  input wire logic strobe_n,
  input wire logic data_n,
  // Captured bits and pin faults
  output logic bit_val,
  output int n_bits,
  output int n_bad
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // Bit capture
  // ----------------------------------------
  initial begin
    bit_val = 1'b0;
    n_bits = 0;
    n_bad = 0;
  end

  // capture on strobe fall, low is one
  always @(negedge strobe_n) begin
    if (card_present_n !== 1'b0) begin
      n_bad = n_bad + 1;
    end
    bit_val = ~data_n;
    n_bits = n_bits + 1;
  end

  function automatic logic [7:0] char_text(input logic [3:0] d);
    if (d == 4'hb) begin
      return 8'h3b;
    end else if (d == 4'hd) begin
      return 8'h3d;
    end else if (d == 4'hf) begin
      return 8'h3f;
    end
    return 8'h30 + 8'(d);
  endfunction

  always @(data_n) begin
    #1;
    if (strobe_n === 1'b0) begin
      n_bad = n_bad + 1;
    end
  end
endmodule

// File: stk_decoder_tb_top.sv
// Testbench for the numeric stripe track decoder
module stk_decoder_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TMO = 2000;
  localparam int CELL = 1000;
  logic clk_sys, sys_rst, clk_head, head_rst, flux_in, track_hi;
  logic card_present_n, strobe_n, data_n, char_valid, bit_val, hunting;
  stk_pkg::stk_char_t char_out;
  stk_pkg::stk_status_t status;
  int n_bits, n_bad, n_fail, num_checks;
  int seed = 32'hf2c0;
  logic [4:0] exp_q[$];
  logic bit_q[$];
  logic [3:0] column_check_char;

  stk_decoder #(.TIMEOUT(TMO), .CELL_W(20), .MAX_LO(stk_pkg::MAX_CHARS_LO), .MAX_HI(7'h01))
    dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .clk_head(clk_head), .head_rst(head_rst), .flux_in(flux_in), .track_hi(track_hi),
    .card_present_n(card_present_n), .strobe_n(strobe_n), .data_n(data_n),
    .char_out(char_out), .char_valid(char_valid), .status(status));
  stk_host_model host (.card_present_n(card_present_n), .strobe_n(strobe_n),
    .data_n(data_n), .bit_val(bit_val), .n_bits(n_bits), .n_bad(n_bad));

  // ----------------------------------------
  // Clocks
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  initial begin
    clk_head = 1'b0;
    #7;
    forever #15 clk_head = ~clk_head;
  end

  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic conclude;
    if (n_fail == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Flux stimulus
  // ----------------------------------------
  task automatic send_bit(input logic b);
    if (b) begin
      repeat (CELL / 2) @(negedge clk_sys);
      flux_in = ~flux_in;
    end
    repeat (b ? CELL / 2 : CELL) @(negedge clk_sys);
    flux_in = ~flux_in;
  endtask
  task automatic send_char(input logic [3:0] d, input logic bad);
    logic [4:0] c;
    c = {~^d ^ bad, d};
    exp_q.push_back(c);
    column_check_char = column_check_char ^ d;
    for (int i = 0; i < 5; i++) begin
      bit_q.push_back(c[i]);
      send_bit(c[i]);
    end
  endtask
  task automatic send_card(input logic hi, input int lead, input int trail, input logic bad,
      input logic [3:0] flip, input logic [5:0] st);
    logic [3:0] d;
    int k;
    track_hi = hi;
    column_check_char = 4'h0;
    hunting = 1'b1;
    for (int i = 0; i < lead; i++) begin
      send_bit(1'b0);
      if (i < 15) begin
        repeat (40) @(negedge clk_sys);
        check(card_present_n, i < 13, "presence");
      end
      if (i == 14) begin
        check(status, 8'h00, "status clear");
      end
    end
    send_char(4'hb, 1'b0);
    d = 4'($unsigned($random(seed)) % 10);
    send_char(d, bad);
    d = 4'($unsigned($random(seed)) % 10);
    send_char(d, 1'b0);
    send_char(4'hf, 1'b0);
    send_char(column_check_char ^ flip, 1'b0);
    for (int i = 0; i < trail; i++) begin
      bit_q.push_back(1'b0);
      send_bit(1'b0);
    end
    repeat (TMO - 100) @(negedge clk_sys);
    check(card_present_n, 8'h00, "early drop");
    k = 0;
    while (card_present_n !== 1'b1 && k < 300) begin
      @(negedge clk_sys);
      k++;
    end
    check(card_present_n, 8'h01, "timeout");
    check(status, st, "status");
    check(8'(exp_q.size()), 8'h00, "missing chars");
    check(8'(bit_q.size()), 8'h00, "missing bits");
  endtask

  // ----------------------------------------
  // Output watchers
  // ----------------------------------------
  always @(negedge clk_sys) begin
    if (char_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        check(8'h01, 8'h00, "extra char");
      end else begin
        check(char_out, exp_q.pop_front(), "char");
      end
    end
  end
  // leading zeros dropped before the first one
  always @(n_bits) begin
    if (!(hunting && bit_val === 1'b0)) begin
      hunting = 1'b0;
      if (bit_q.size() == 0) begin
        check(8'h01, 8'h00, "extra bit");
      end else begin
        check(bit_val, bit_q.pop_front(), "pin bit");
      end
    end
  end
  initial begin
    repeat (99000) @(posedge clk_sys);
    check(8'h01, 8'h00, "hang");
    conclude();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    sys_rst = 1'b1;
    head_rst = 1'b1;
    flux_in = 1'b0;
    track_hi = 1'b0;
    hunting = 1'b1;
    n_fail = 0;
    num_checks = 0;
    repeat (10) @(negedge clk_sys);
    sys_rst = 1'b0;
    repeat (20) @(negedge clk_sys);
    head_rst = 1'b0;
    check({card_present_n, strobe_n, data_n}, 8'h07, "idle");
    send_card(1'b0, 22, 2, 1'b0, 4'h0, 6'h31);
    send_card(1'b1, 16, 2, 1'b1, 4'h6, 6'h3f);
    check(8'(n_bad), 8'h00, "pin faults");
    check(host.char_text(4'hd), 8'h3d, "field text");
    conclude();
  end
endmodule
